// ### hw/cprs_defs.vh
/*
 * Constants for the power-on and configuration reset sequencer.
 * Assumes a 125 MHz ref_clk; included by its bare name.
 */
`ifndef CPRS_DEFS_VH
`define CPRS_DEFS_VH

`define CPRS_CLK_MHZ          125
// power-on windows, microseconds
`define CPRS_FAST_MIN_US      4000
`define CPRS_FAST_MAX_US      12000
`define CPRS_STD_MIN_US       100000
`define CPRS_STD_MAX_US       300000
// chosen targets inside each window
`define CPRS_FAST_US          8000
`define CPRS_STD_US           200000
// the targets above in ref_clk cycles, sized to the delay counter
`define CPRS_FAST_CYC         25'h00F4240
`define CPRS_STD_CYC          25'h17D7840
// configuration memory size
`define CPRS_MEM_AW           8
`define CPRS_MEM_WORDS        256
`define CPRS_MEM_DW           8
`define CPRS_MEM_CLEAR_VAL    8'h00
`define CPRS_CNT_W            25

`endif

// ### hw/cprs_cfg_clear.v
/*
 * Configuration memory with a sequential clear engine.
 * Assumes the sequencer starts the clear and waits for clear_done.
 */
`include "cprs_defs.vh"

module cprs_cfg_clear (
  input  wire                      ref_clk,
  input  wire                      rst,
  // control
  input  wire                      clear_start,
  output reg                       clear_done_q,
  // write and read ports for later configuration data
  input  wire                      wr_en,
  input  wire [`CPRS_MEM_AW-1:0]   wr_addr,
  input  wire [`CPRS_MEM_DW-1:0]   wr_data,
  input  wire [`CPRS_MEM_AW-1:0]   rd_addr,
  output reg  [`CPRS_MEM_DW-1:0]   rd_data_q
);

  reg [`CPRS_MEM_DW-1:0] mem [0:`CPRS_MEM_WORDS-1];
  reg [`CPRS_MEM_AW-1:0] clr_addr_q;
  reg                    clearing_q;

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      clr_addr_q   <= {`CPRS_MEM_AW{1'b0}};
      clearing_q   <= 1'b0;
      clear_done_q <= 1'b0;
    end else if (clear_start) begin
      clr_addr_q   <= {`CPRS_MEM_AW{1'b0}};
      clearing_q   <= 1'b1;
      clear_done_q <= 1'b0;
    end else if (clearing_q) begin
      clr_addr_q <= clr_addr_q + 1'b1;
      if (&clr_addr_q) begin
        clearing_q   <= 1'b0;
        clear_done_q <= 1'b1;
      end
    end
  end

  // memory has no reset; clearing walks every word
  always @(posedge ref_clk) begin
    if (clearing_q)
      mem[clr_addr_q] <= `CPRS_MEM_CLEAR_VAL;
    else if (wr_en)
      mem[wr_addr] <= wr_data;
    rd_data_q <= mem[rd_addr];
  end

endmodule // cprs_cfg_clear

// ### hw/cprs_sequencer.v
/*
 * Power-on reset and configuration reset sequencer.
 * Assumes pins are synchronous to ref_clk except config_request_n,
 * which is synchronised here; rst models the power-on trip.
 */
`include "cprs_defs.vh"

// How it works
// - in power-on reset, status is low, memory is cleared, user I/O floats.
// - after power-on reset, user I/O stays floated through configuration.
// - while the request input is low the block stays in reset.
// - status is driven low until the request input is high, then released.
// - once status reads high externally, the block is ready for data.
// - pull-up select low turns weak pull-ups on after power-on reset.
// - with the pull-up select high, weak pull-ups stay off.
// - the power-on delay length follows the scheme strap pins while strap_use_por_sel is low.
// - power-on time select low gives the standard delay, high the fast one.
// - fast delay lies in 4 to 12 ms, standard delay in 100 to 300 ms.
// - a low request also pulls status and config-complete low, I/O floats.
module cprs_sequencer #(
  parameter [`CPRS_CNT_W-1:0] FAST_CYC = `CPRS_FAST_CYC,
  parameter [`CPRS_CNT_W-1:0] STD_CYC  = `CPRS_STD_CYC
) (
  // clock and power-on reset
  input  wire                    ref_clk,
  input  wire                    rst,
  // strap and select pins
  input  wire [3:0]              config_scheme_strap,
  input  wire                    por_time_select,
  input  wire                    strap_use_por_sel,
  input  wire                    io_weak_pullup_select_n,
  // configuration request from the host
  input  wire                    config_request_n,
  // open-drain status line
  input  wire                    config_status_n_in,
  output wire                    config_status_n_out,
  output wire                    config_status_n_oe,
  // open-drain config complete line
  output wire                    config_complete_out,
  output wire                    config_complete_oe,
  // user I/O control
  output reg                     user_io_tristate_q,
  output reg                     user_io_weak_pullup_q,
  // sequence status
  output reg                     config_ready_q,
  output reg                     por_active_q,
  // configuration memory access
  input  wire                    cfg_wr_en,
  input  wire [`CPRS_MEM_AW-1:0] cfg_wr_addr,
  input  wire [`CPRS_MEM_DW-1:0] cfg_wr_data,
  input  wire [`CPRS_MEM_AW-1:0] cfg_rd_addr,
  output wire [`CPRS_MEM_DW-1:0] cfg_rd_data
);

  // one-hot state codes
  localparam [4:0] ST_POR   = 5'b00001;
  localparam [4:0] ST_CLEAR = 5'b00010;
  localparam [4:0] ST_RESET = 5'b00100;
  localparam [4:0] ST_WAIT  = 5'b01000;
  localparam [4:0] ST_READY = 5'b10000;

  // strap table: schemes 1010 and 1011 take the standard delay
  function strap_is_std;
    input [3:0] strap;
    begin
      strap_is_std = (strap == 4'hA) || (strap == 4'hB);
    end
  endfunction

  // power-on covers both the delay and the memory clear
  function in_power_on;
    input [4:0] st;
    begin
      in_power_on = (st == ST_POR) || (st == ST_CLEAR);
    end
  endfunction

  // status stays low in every state before the request is seen high
  function holds_status_low;
    input [4:0] st;
    begin
      holds_status_low = in_power_on(st) || (st == ST_RESET);
    end
  endfunction

  reg  [4:0]            state_q;
  reg  [4:0]            state_d;
  reg  [`CPRS_CNT_W-1:0] por_cnt_q;
  reg  [`CPRS_CNT_W-1:0] por_len_q;
  reg                   strap_seen_q;
  reg                   req_meta_q;
  reg                   req_sync_q;
  reg                   status_low_q;
  reg                   clear_start_q;
  wire                  clear_done;
  wire                  want_std;

  // first stage is read only by the second stage
  // resets low, so the block sits in reset until a request is seen
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      req_meta_q <= 1'b0;
      req_sync_q <= 1'b0;
    end else begin
      req_meta_q <= config_request_n;
      req_sync_q <= req_meta_q;
    end
  end

  // either the strap or the select pin picks the delay
  assign want_std = strap_use_por_sel
                  ? ~por_time_select
                  : strap_is_std(config_scheme_strap);

  // straps are caught by a clocked process after reset release
  // read once, so a strap that moves later cannot change the delay
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      strap_seen_q <= 1'b0;
      por_len_q    <= {`CPRS_CNT_W{1'b0}};
    end else if (!strap_seen_q) begin
      strap_seen_q <= 1'b1;
      por_len_q    <= want_std ? STD_CYC : FAST_CYC;
    end
  end

  // next state; a low request beats every state after the clear
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_POR: begin
        // the length is latched, so the compare never sees it move
        if (strap_seen_q && (por_cnt_q >= por_len_q))
          state_d = ST_CLEAR;
      end
      ST_CLEAR: begin
        // done only counts once the start pulse has gone
        if (clear_done && !clear_start_q)
          state_d = ST_RESET;
      end
      ST_RESET: begin
        if (req_sync_q)
          state_d = ST_WAIT;
      end
      ST_WAIT: begin
        if (!req_sync_q)
          state_d = ST_RESET;
        else if (config_status_n_in)
          state_d = ST_READY;
      end
      ST_READY: begin
        if (!req_sync_q)
          state_d = ST_RESET;
      end
      default: state_d = ST_POR;
    endcase
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q       <= ST_POR;
      clear_start_q <= 1'b0;
    end else begin
      state_q       <= state_d;
      clear_start_q <= (state_q == ST_POR) && (state_d == ST_CLEAR);
    end
  end

  // delay counter runs only once the delay length has been latched
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      por_cnt_q <= {`CPRS_CNT_W{1'b0}};
    end else if ((state_q == ST_POR) && strap_seen_q) begin
      por_cnt_q <= por_cnt_q + 1'b1;
    end
  end

  // a low request does not re-clear memory: clearing belongs to power-on
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      status_low_q          <= 1'b1;
      user_io_tristate_q    <= 1'b1;
      user_io_weak_pullup_q <= 1'b0;
      config_ready_q        <= 1'b0;
      por_active_q          <= 1'b1;
    end else begin
      por_active_q <= in_power_on(state_d);
      // status driven low until the request is seen high
      status_low_q <= holds_status_low(state_d);
      // user I/O never leaves high impedance in this stage
      user_io_tristate_q <= 1'b1;
      // pull-ups wait for the end of power-on, then follow the select pin
      user_io_weak_pullup_q <= !io_weak_pullup_select_n &&
                               !in_power_on(state_d);
      config_ready_q <= (state_d == ST_READY);
    end
  end

  // open-drain: drive low or float, the board pull-up gives the high
  assign config_status_n_out = 1'b0;
  assign config_status_n_oe  = status_low_q;
  // config complete is only ever pulled low in this stage
  assign config_complete_out = 1'b0;
  assign config_complete_oe  = 1'b1;

  // writes are refused until the block reports ready
  cprs_cfg_clear u_clear (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .clear_start  (clear_start_q),
    .clear_done_q (clear_done),
    .wr_en        (cfg_wr_en & config_ready_q),
    .wr_addr      (cfg_wr_addr),
    .wr_data      (cfg_wr_data),
    .rd_addr      (cfg_rd_addr),
    .rd_data_q    (cfg_rd_data)
  );

endmodule // cprs_sequencer

// ### tb/cprs_seq_checker.sv
/* Checker for the reset sequencer's pin behaviour.
   Assumes one clock and the async high rst of the top. */
module cprs_seq_checker (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // pins
  input wire logic config_request_n,
  input wire logic io_weak_pullup_select_n,
  input wire logic config_status_n_in,
  input wire logic config_status_n_oe,
  input wire logic config_complete_out,
  input wire logic config_complete_oe,
  // sequence outputs
  input wire logic user_io_tristate_q,
  input wire logic user_io_weak_pullup_q,
  input wire logic config_ready_q,
  input wire logic por_active_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_io_float: assert property (user_io_tristate_q)
    else $error("user io driven");
  a_por_status: assert property (por_active_q |-> config_status_n_oe)
    else $error("status released in power-on");
  a_por_pullup: assert property (por_active_q
    |-> !user_io_weak_pullup_q)
    else $error("pull-ups on in power-on");
  a_pullup_off: assert property (io_weak_pullup_select_n ##1
    io_weak_pullup_select_n |-> !user_io_weak_pullup_q)
    else $error("pull-ups on while deselected");
  a_req_hold: assert property (!config_request_n [*4]
    |-> config_status_n_oe && !config_ready_q)
    else $error("not held in reset by request");
  a_status_release: assert property ($fell(config_status_n_oe)
    |-> $past(config_request_n, 3))
    else $error("status released without request high");
  a_ready_cause: assert property ($rose(config_ready_q)
    |-> $past(config_status_n_in) && !config_status_n_oe)
    else $error("ready without status high");
  a_complete_low: assert property (config_complete_oe
    && !config_complete_out)
    else $error("complete line not held low");
endmodule // cprs_seq_checker

bind cprs_sequencer cprs_seq_checker chk_u (.ref_clk, .rst,
  .config_request_n, .io_weak_pullup_select_n, .config_status_n_in,
  .config_status_n_oe, .config_complete_out, .config_complete_oe,
  .user_io_tristate_q, .user_io_weak_pullup_q, .config_ready_q,
  .por_active_q);

// ### tb/cprs_host_model.sv
/* Configuration host: drives the request line.
   Assumes supply_ok from the bench; lag sets a slow answer. */
module cprs_host_model (
  // inputs
  input  wire logic       ref_clk,
  input  wire logic       supply_ok,
  input  wire logic [7:0] lag,
  // request pin
  output logic            config_request_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] wait_q;
  initial begin
    config_request_n = 1'b0;
    wait_q = 8'h00;
  end
  // held low until supplies are stable, then released after lag
  always @(negedge ref_clk) begin
    if (!supply_ok) begin
      config_request_n <= 1'b0;
      wait_q <= 8'h00;
    end else if (wait_q < lag) begin
      wait_q <= wait_q + 8'h01;
    end else begin
      config_request_n <= 1'b1;
    end
  end
endmodule // cprs_host_model

// ### tb/cprs_sequencer_test.sv
/* Self-checking bench for the reset sequencer.
   Assumes short power-on counts of 20 and 50 cycles. */
module cprs_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk, rst, pts, use_sel, pu_n, sup, wr_en, st_in;
  logic       st_out, st_oe, req_n, cc_out, cc_oe, tri_q, pu_q, rdy, por;
  logic [3:0] strap;
  logic [7:0] wr_addr, wr_data, rd_addr, rd_data;
  int         mismatches, total_checks, cyc, n;
  assign st_in = st_oe ? st_out : 1'b1; // external pull-up
  cprs_sequencer #(.FAST_CYC(25'd20), .STD_CYC(25'd50)) dut_u (
    .ref_clk(clk), .rst(rst), .config_scheme_strap(strap),
    .por_time_select(pts), .strap_use_por_sel(use_sel),
    .io_weak_pullup_select_n(pu_n), .config_request_n(req_n),
    .config_status_n_in(st_in), .config_status_n_out(st_out),
    .config_status_n_oe(st_oe), .config_complete_out(cc_out),
    .config_complete_oe(cc_oe), .user_io_tristate_q(tri_q),
    .user_io_weak_pullup_q(pu_q), .config_ready_q(rdy),
    .por_active_q(por), .cfg_wr_en(wr_en), .cfg_wr_addr(wr_addr),
    .cfg_wr_data(wr_data), .cfg_rd_addr(rd_addr), .cfg_rd_data(rd_data));
  cprs_host_model host_u (.ref_clk(clk), .supply_ok(sup), .lag(8'h05),
    .config_request_n(req_n));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task por_run(input logic u, input logic p, input logic [3:0] s,
               output int cnt);
    cnt = 0;
    rst = 1'b1;
    use_sel = u;
    pts = p;
    strap = s;
    repeat (8) @(negedge clk);
    chk({tri_q, st_oe, pu_q, por}, 32'hD);
    rst = 1'b0;
    while (por !== 1'b0 && cnt < 2000) begin
      @(negedge clk);
      cnt++;
    end
  endtask
  task wait_rdy;
    for (n = 0; rdy !== 1'b1 && n < 60; n++) @(negedge clk);
  endtask
  task write_rd(input logic w, input logic [7:0] d);
    wr_en = w;
    wr_data = d;
    @(negedge clk);
    wr_en = 1'b0;
    @(negedge clk);
  endtask
  task t_por_time;
    int a, b;
    por_run(1'b1, 1'b1, 4'h0, a);
    por_run(1'b1, 1'b0, 4'h0, b);
    chk(32'(b - a), 32'h1E);
    por_run(1'b0, 1'b1, 4'hB, b);
    por_run(1'b0, 1'b0, 4'h3, a);
    chk(32'(b - a), 32'h1E);
    $display("power-on timing done");
  endtask
  task t_release;
    sup = 1'b0;
    por_run(1'b1, 1'b1, 4'h0, n);
    chk(rd_data, 32'h0);
    rd_addr = 8'hFF;
    repeat (10) @(negedge clk);
    chk({st_oe, rdy, st_out, st_in}, 32'h8);
    chk(rd_data, 32'h0);
    rd_addr = 8'h3C;
    sup = 1'b1;
    wait_rdy();
    chk({rdy, pu_q, tri_q, st_in}, 32'hF);
    write_rd(1'b1, 8'h5A);
    chk(rd_data, 32'h5A);
    $display("release done");
  endtask
  task t_req_low;
    sup = 1'b0;
    repeat (4) @(negedge clk);
    chk({st_oe, rdy, cc_oe, cc_out}, 32'hA);
    write_rd(1'b1, 8'hC3);
    sup = 1'b1;
    wait_rdy();
    write_rd(1'b0, 8'h00);
    chk(rd_data, 32'h5A);
    pu_n = 1'b1;
    repeat (3) @(negedge clk);
    chk(pu_q, 32'h0);
    pu_n = 1'b0;
    $display("request low done");
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // hang guard, well above the roughly 1550 cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      mismatches++;
      test_done();
    end
  end
  initial begin
    {rst, pts, use_sel, pu_n, sup, wr_en, strap} = 10'h200;
    {wr_addr, wr_data, rd_addr} = 24'h3C003C;
    {mismatches, total_checks, cyc} = '0;
    t_por_time();
    t_release();
    t_req_low();
    test_done();
  end
endmodule // cprs_sequencer_test
